// ===== hdl/afb_pkg.sv
// Constants, register map and types for the auto-forward status register bank.
// Operation
// - Hold the upper gap byte of the transmit message gap count; resets to zero.
// - Hold the lower gap byte separately; resets to nine, giving a nine-zero gap.
// - Padding enable bit 6 allows zeros between units; clear means no padding.
// - User forward enable bit 5 copies received user bits into the transmitter.
// - Status forward enable bit 4 copies received channel-status bits to transmitter, except one arriving in the same cycle as a forwarded user bit.
// - Low nibble gives maximum zeros between units; codes zero to eight.
// - Report read-only 15-bit rate ratio; bits 14..8 upper, bit 7 reserved.
// - Show 16-bit Pc burst word over two bytes on detection, else zero.
// - Show 16-bit Pd burst word over two bytes on detection, else zero.
// - With per-subframe burst data, Pd registers hold channel B Pc word.
// - Flag a non-audio stream whenever a burst preamble is detected.
package afb_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_GAP_HIGH = 7'h0F;
    localparam logic [ADDR_W-1:0] OFS_GAP_LOW = 7'h10;
    localparam logic [ADDR_W-1:0] OFS_FWD_CTRL = 7'h11;
    localparam logic [ADDR_W-1:0] OFS_RATIO_HIGH = 7'h12;
    localparam logic [ADDR_W-1:0] OFS_RATIO_LOW = 7'h13;
    localparam logic [ADDR_W-1:0] OFS_PC_HIGH = 7'h14;
    localparam logic [ADDR_W-1:0] OFS_PC_LOW = 7'h15;
    localparam logic [ADDR_W-1:0] OFS_PD_HIGH = 7'h16;
    localparam logic [ADDR_W-1:0] OFS_PD_LOW = 7'h17;
    localparam logic [DATA_W-1:0] RST_GAP_HIGH = 8'h00;
    localparam logic [DATA_W-1:0] RST_GAP_LOW = 8'h09;
    localparam logic [DATA_W-1:0] RST_FWD_CTRL = 8'h00;
    localparam logic [DATA_W-1:0] FWD_CTRL_MASK = 8'h7F;
    localparam int BIT_PAD_EN = 6;
    localparam int BIT_USER_FWD = 5;
    localparam int BIT_CS_FWD = 4;
    localparam int PAD_MAX_LSB = 0;
    localparam int PAD_MAX_W = 4;
    localparam logic [PAD_MAX_W-1:0] PAD_MAX_LIMIT = 4'h8;
    localparam logic [PAD_MAX_W-1:0] PAD_ZERO = 4'h0;
    localparam logic [PAD_MAX_W-1:0] PAD_ONE = 4'h1;
    localparam int RATIO_W = 15;
    localparam int BURST_W = 16;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [BURST_W-1:0] BURST_ZERO = 16'h0000;
    localparam logic [RATIO_W-1:0] RATIO_ZERO = 15'h0000;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 2;
    localparam int ITEM_KIND = 1;
    localparam int ITEM_BIT = 0;
    typedef enum logic [0:0] {AFB_PASS, AFB_PAD} afb_pad_state_t;
endpackage : afb_pkg

// ===== hdl/afb_fifo_if.sv
// Carrier between the forwarding logic and its bit FIFO.
`timescale 1ns/1ns
interface afb_fifo_if #(parameter int WIDTH = 2);
    logic pushValid;
    logic [WIDTH-1:0] pushData;
    logic pushReady;
    logic popValid;
    logic [WIDTH-1:0] popData;
    logic popReady;
    modport fifo_side (input pushValid, input pushData, output pushReady,
                       output popValid, output popData, input popReady);
    modport user_side (output pushValid, output pushData, input pushReady,
                       input popValid, input popData, output popReady);
endinterface : afb_fifo_if

// ===== hdl/afb_fifo.sv
// Synchronous FIFO holding forwarded user and channel-status bits.
`timescale 1ns/1ns
module afb_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    afb_fifo_if.fifo_side link
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CNT_W-1:0] count;

    wire logic isFull = (count == CNT_FULL);
    wire logic isEmpty = (count == '0);
    wire logic doPush = link.pushValid && !isFull;
    wire logic doPop = link.popReady && !isEmpty;
    wire logic [PTR_W-1:0] next_wrPtr = (wrPtr == PTR_LAST) ? '0 : wrPtr + 1'b1;
    wire logic [PTR_W-1:0] next_rdPtr = (rdPtr == PTR_LAST) ? '0 : rdPtr + 1'b1;

    assign link.pushReady = !isFull;
    assign link.popValid = !isEmpty;
    assign link.popData = store[rdPtr];

    always_ff @(posedge sys_clk) begin
        if (ce && doPush) begin
            store[wrPtr] <= link.pushData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else if (ce) begin
            if (doPush) begin
                wrPtr <= next_wrPtr;
            end
            if (doPop) begin
                rdPtr <= next_rdPtr;
            end
            if (doPush && !doPop) begin
                count <= count + 1'b1;
            end else if (doPop && !doPush) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : afb_fifo

// ===== hdl/afb_regs.sv
// Register bank and auto-forwarding path between receiver and transmitter bits.
`timescale 1ns/1ns
module afb_regs #(
    parameter int FIFO_DEPTH_P = afb_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [afb_pkg::ADDR_W-1:0] regAddr,
    input wire logic [afb_pkg::DATA_W-1:0] regWdata,
    output logic [afb_pkg::DATA_W-1:0] regRdata,
    output logic regRvalid,
    output logic [afb_pkg::BURST_W-1:0] messageGap,
    output logic userFwdActive,
    output logic csFwdActive,
    input wire logic [afb_pkg::RATIO_W-1:0] rateRatioIn,
    input wire logic burstDetect,
    input wire logic burstLost,
    input wire logic subframeMode,
    input wire logic [afb_pkg::BURST_W-1:0] burstPcIn,
    input wire logic [afb_pkg::BURST_W-1:0] burstPdIn,
    input wire logic [afb_pkg::BURST_W-1:0] burstPcChanBIn,
    output logic nonAudioPreamble,
    input wire logic rxUserValid,
    input wire logic rxUserBit,
    input wire logic rxCsValid,
    input wire logic rxCsBit,
    input wire logic rxUnitEnd,
    output logic rxReady,
    output logic txValid,
    output logic txBit,
    output logic txIsStatus,
    input wire logic txReady
);
    import afb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [DATA_W-1:0] gapHigh;
    logic [DATA_W-1:0] gapLow;
    logic [DATA_W-1:0] fwdCtrl;
    logic [RATIO_W-1:0] rateRatio;
    logic [BURST_W-1:0] burstPc;
    logic [BURST_W-1:0] burstPd;

    wire logic wrGapHigh = regWrite && (regAddr == OFS_GAP_HIGH);
    wire logic wrGapLow = regWrite && (regAddr == OFS_GAP_LOW);
    wire logic wrFwdCtrl = regWrite && (regAddr == OFS_FWD_CTRL);

    wire logic padEnable = fwdCtrl[BIT_PAD_EN];
    wire logic userFwdEnable = fwdCtrl[BIT_USER_FWD];
    wire logic csFwdEnable = fwdCtrl[BIT_CS_FWD];
    wire logic [PAD_MAX_W-1:0] padMaxField = fwdCtrl[PAD_MAX_LSB +: PAD_MAX_W];
    // Codes above eight are clamped so a bad write cannot stretch the gap.
    wire logic [PAD_MAX_W-1:0] padMax = (padMaxField > PAD_MAX_LIMIT) ? PAD_MAX_LIMIT : padMaxField;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            gapHigh <= RST_GAP_HIGH;
            gapLow <= RST_GAP_LOW;
            fwdCtrl <= RST_FWD_CTRL;
        end else if (ce) begin
            if (wrGapHigh) begin
                gapHigh <= regWdata;
            end
            if (wrGapLow) begin
                gapLow <= regWdata;
            end
            if (wrFwdCtrl) begin
                fwdCtrl <= regWdata & FWD_CTRL_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status capture: ratio and burst preamble words.

    // Detection wins over loss in the same cycle so a fresh burst is never missed.
    wire logic next_nonAudio = burstDetect ? 1'b1 : (burstLost ? 1'b0 : nonAudioPreamble);
    wire logic [BURST_W-1:0] pdSource = subframeMode ? burstPcChanBIn : burstPdIn;
    wire logic [BURST_W-1:0] next_burstPc = burstDetect ? burstPcIn : (burstLost ? BURST_ZERO : burstPc);
    wire logic [BURST_W-1:0] next_burstPd = burstDetect ? pdSource : (burstLost ? BURST_ZERO : burstPd);

    // The status words have no write path at all, so bus writes cannot touch them.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rateRatio <= RATIO_ZERO;
            burstPc <= BURST_ZERO;
            burstPd <= BURST_ZERO;
            nonAudioPreamble <= 1'b0;
        end else if (ce) begin
            rateRatio <= rateRatioIn;
            burstPc <= next_burstPc;
            burstPd <= next_burstPd;
            nonAudioPreamble <= next_nonAudio;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read decode.

    logic [DATA_W-1:0] readMux;

    always_comb begin
        readMux = BYTE_ZERO;
        case (regAddr)
            OFS_GAP_HIGH: readMux = gapHigh;
            OFS_GAP_LOW: readMux = gapLow;
            OFS_FWD_CTRL: readMux = fwdCtrl;
            OFS_RATIO_HIGH: readMux = {1'b0, rateRatio[RATIO_W-1:DATA_W]};
            OFS_RATIO_LOW: readMux = rateRatio[DATA_W-1:0];
            OFS_PC_HIGH: readMux = burstPc[BURST_W-1:DATA_W];
            OFS_PC_LOW: readMux = burstPc[DATA_W-1:0];
            OFS_PD_HIGH: readMux = burstPd[BURST_W-1:DATA_W];
            OFS_PD_LOW: readMux = burstPd[DATA_W-1:0];
            default: readMux = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            regRdata <= BYTE_ZERO;
            regRvalid <= 1'b0;
            messageGap <= {RST_GAP_HIGH, RST_GAP_LOW};
            userFwdActive <= 1'b0;
            csFwdActive <= 1'b0;
        end else if (ce) begin
            regRvalid <= regRead;
            if (regRead) begin
                regRdata <= readMux;
            end
            messageGap <= {gapHigh, gapLow};
            userFwdActive <= userFwdEnable;
            csFwdActive <= csFwdEnable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Forwarding path with padding between information units.

    afb_fifo_if #(.WIDTH(FIFO_WIDTH)) fifoLink ();

    afb_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH_P)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .link(fifoLink.fifo_side)
    );

    afb_pad_state_t padState;
    afb_pad_state_t next_padState;
    logic [PAD_MAX_W-1:0] padLeft;
    logic [PAD_MAX_W-1:0] next_padLeft;

    wire logic inPad = (padState == AFB_PAD);
    wire logic userTake = rxUserValid && userFwdEnable && !inPad;
    wire logic csTake = rxCsValid && csFwdEnable && !inPad && !userTake;
    // Padding only starts at a unit end with forwarding of user bits on.
    wire logic padStart = rxUnitEnd && userFwdEnable && padEnable && (padMax != PAD_ZERO) && !inPad;

    assign fifoLink.pushValid = inPad || userTake || csTake;
    assign fifoLink.pushData = inPad ? {1'b0, 1'b0} : (userTake ? {1'b0, rxUserBit} : {1'b1, rxCsBit});
    wire logic padPushed = inPad && fifoLink.pushReady;

    always_comb begin
        next_padState = padState;
        next_padLeft = padLeft;
        case (padState)
            AFB_PASS: begin
                if (padStart) begin
                    next_padState = AFB_PAD;
                    next_padLeft = padMax;
                end
            end
            AFB_PAD: begin
                if (!padEnable) begin
                    next_padState = AFB_PASS;
                    next_padLeft = PAD_ZERO;
                end else if (padPushed) begin
                    next_padLeft = padLeft - PAD_ONE;
                    if (padLeft == PAD_ONE) begin
                        next_padState = AFB_PASS;
                    end
                end
            end
            default: begin
                next_padState = AFB_PASS;
                next_padLeft = PAD_ZERO;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            padState <= AFB_PASS;
            padLeft <= PAD_ZERO;
            rxReady <= 1'b0;
        end else if (ce) begin
            padState <= next_padState;
            padLeft <= next_padLeft;
            // Registered ready lags the FIFO by one cycle; a bit offered into a full FIFO is dropped.
            rxReady <= fifoLink.pushReady && (next_padState == AFB_PASS);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output register toward the transmitter.

    wire logic outFree = !txValid || txReady;
    assign fifoLink.popReady = outFree;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txValid <= 1'b0;
            txBit <= 1'b0;
            txIsStatus <= 1'b0;
        end else if (ce && outFree) begin
            txValid <= fifoLink.popValid;
            txBit <= fifoLink.popData[ITEM_BIT];
            txIsStatus <= fifoLink.popData[ITEM_KIND];
        end
    end
endmodule : afb_regs

// ===== tb/afb_regs_sva.sv
// Checker for the register bank and the forwarding path, bound to its ports.
`timescale 1ns/1ns
module afb_regs_sva #(
    parameter int FIFO_DEPTH_P = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [afb_pkg::ADDR_W-1:0] regAddr,
    input wire logic [afb_pkg::DATA_W-1:0] regWdata,
    input wire logic [afb_pkg::DATA_W-1:0] regRdata,
    input wire logic regRvalid,
    input wire logic [afb_pkg::BURST_W-1:0] messageGap,
    input wire logic userFwdActive,
    input wire logic [afb_pkg::RATIO_W-1:0] rateRatioIn,
    input wire logic burstDetect,
    input wire logic burstLost,
    input wire logic nonAudioPreamble,
    input wire logic rxUserValid,
    input wire logic rxReady,
    input wire logic txValid,
    input wire logic txBit,
    input wire logic txIsStatus,
    input wire logic txReady
);
    import afb_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd(a);
        ce && regRead && regAddr == a;
    endsequence
    sequence s_offer;
        ce && rxUserValid && rxReady && userFwdActive && !txValid;
    endsequence
    property p_rvalid; ce && regRead |=> regRvalid; endproperty
    property p_rvalid_pulse; !(ce && regRead) |=> !regRvalid; endproperty
    property p_ratio_high; s_rd(OFS_RATIO_HIGH) |=> regRdata == {1'h0, $past(rateRatioIn[14:8], 2)}; endproperty
    property p_ratio_low; s_rd(OFS_RATIO_LOW) |=> regRdata == $past(rateRatioIn[7:0], 2); endproperty
    property p_ctrl_top; s_rd(OFS_FWD_CTRL) |=> !regRdata[7]; endproperty
    property p_gap_wr; ce && regWrite && regAddr == OFS_GAP_LOW |=> ##1 messageGap[7:0] == $past(regWdata, 2); endproperty
    property p_fwd_wr; ce && regWrite && regAddr == OFS_FWD_CTRL |=> ##1 userFwdActive == $past(regWdata[5], 2); endproperty
    property p_flag_set; ce && burstDetect |=> nonAudioPreamble; endproperty
    property p_flag_clr; ce && burstLost && !burstDetect |=> !nonAudioPreamble; endproperty
    property p_fwd; s_offer |-> ##[1:3] txValid; endproperty
    property p_tx_hold; txValid && !txReady |=> txValid && $stable(txBit) && $stable(txIsStatus); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read");
    a_ratio_high: assert property (p_ratio_high) else $error("ratio upper byte wrong");
    a_ratio_low: assert property (p_ratio_low) else $error("ratio lower byte wrong");
    a_ctrl_top: assert property (p_ctrl_top) else $error("control bit 7 set");
    a_gap_wr: assert property (p_gap_wr) else $error("gap lower byte not taken");
    a_fwd_wr: assert property (p_fwd_wr) else $error("user forward enable wrong");
    a_flag_set: assert property (p_flag_set) else $error("burst flag not set");
    a_flag_clr: assert property (p_flag_clr) else $error("burst flag not cleared");
    a_fwd: assert property (p_fwd) else $error("user bit not forwarded");
    a_tx_hold: assert property (p_tx_hold) else $error("tx word changed while stalled");
endmodule : afb_regs_sva
bind afb_regs afb_regs_sva #(.FIFO_DEPTH_P(FIFO_DEPTH_P)) CHK (.sys_clk, .rst_n, .ce, .regWrite, .regRead,
    .regAddr, .regWdata, .regRdata, .regRvalid, .messageGap, .userFwdActive, .rateRatioIn, .burstDetect,
    .burstLost, .nonAudioPreamble, .rxUserValid, .rxReady, .txValid, .txBit, .txIsStatus, .txReady);

// ===== tb/afb_tx_sink.sv
// Transmitter-side sink that takes forwarded words and can stall.
`timescale 1ns/1ns
module afb_tx_sink (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic txValid,
    input wire logic txBit,
    input wire logic txIsStatus,
    output logic txReady,
    output logic [7:0] wordCount,
    output logic [1:0] lastWord
);
    // A busy serializer refuses every word, so the FIFO fills to its depth and later bits are dropped.
    assign txReady = !stall;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wordCount <= 8'h00;
            lastWord <= 2'h0;
        end else if (txValid && txReady) begin
            wordCount <= wordCount + 8'h01;
            lastWord <= {txIsStatus, txBit};
        end
    end
endmodule : afb_tx_sink

// ===== tb/spdif_autobuffer_status_regs_tb.sv
// Self-checking bench for the auto-forward status register bank.
`timescale 1ns/1ns
module spdif_autobuffer_status_regs_tb;
    import afb_pkg::*;
    logic sys_clk = 0, rst_n = 0, ce = 1, regWrite = 0, regRead = 0, stall = 0;
    logic [ADDR_W-1:0] regAddr = 7'h00;
    logic [DATA_W-1:0] regWdata = 8'h00, regRdata;
    logic [RATIO_W-1:0] rateRatioIn = 15'h5A3C;
    logic burstDetect = 0, burstLost = 0, subframeMode = 0, rxUnitEnd = 0;
    logic [BURST_W-1:0] burstPcIn = 16'h1234, burstPdIn = 16'h5678, burstPcChanBIn = 16'h9ABC, messageGap;
    logic rxUserValid = 0, rxUserBit = 0, rxCsValid = 0, rxCsBit = 0;
    logic regRvalid, userFwdActive, csFwdActive, nonAudioPreamble, rxReady, txValid, txBit, txIsStatus, txReady;
    logic [7:0] wordCount, base;
    logic [1:0] lastWord;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    afb_regs #(.FIFO_DEPTH_P(FIFO_DEPTH)) DUT (.sys_clk, .rst_n, .ce, .regWrite, .regRead, .regAddr, .regWdata,
        .regRdata, .regRvalid, .messageGap, .userFwdActive, .csFwdActive, .rateRatioIn, .burstDetect, .burstLost,
        .subframeMode, .burstPcIn, .burstPdIn, .burstPcChanBIn, .nonAudioPreamble, .rxUserValid, .rxUserBit,
        .rxCsValid, .rxCsBit, .rxUnitEnd, .rxReady, .txValid, .txBit, .txIsStatus, .txReady);
    afb_tx_sink SINK (.sys_clk, .rst_n, .stall, .txValid, .txBit, .txIsStatus, .txReady, .wordCount, .lastWord);
    ////////////////////////////////////////
    initial begin
        forever #10 sys_clk = !sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done;
        end
    end
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    task tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge sys_clk) {regWrite, regAddr, regWdata} = {1'h1, a, d};
        @(negedge sys_clk) regWrite = 0;
    endtask : wr
    task rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge sys_clk) {regRead, regAddr} = {1'h1, a};
        @(negedge sys_clk) regRead = 0;
        chk("rvalid", 16'h1, 16'(regRvalid));
        chk($sformatf("reg %h", a), 16'(e), 16'(regRdata));
    endtask : rd
    task offer(input logic cs, input logic b);
        @(negedge sys_clk) {rxUserValid, rxCsValid, rxUserBit, rxCsBit} = {!cs, cs, b, b};
        @(negedge sys_clk) {rxUserValid, rxCsValid} = 2'h0;
    endtask : offer
    task burst(input logic sub, input logic det, input logic [31:0] e);
        @(negedge sys_clk) {subframeMode, burstDetect, burstLost} = {sub, det, !det};
        @(negedge sys_clk) {burstDetect, burstLost} = 2'h0;
        chk("flag", 16'(det), 16'(nonAudioPreamble));
        for (int i = 0; i < 4; i++) rd(7'(OFS_PC_HIGH + i), e[31-8*i -: 8]);
    endtask : burst
    task fwd(input logic [7:0] c, input logic cs, input logic ue, input logic [7:0] add, input logic [1:0] last);
        wr(OFS_FWD_CTRL, c);
        rd(OFS_FWD_CTRL, c & FWD_CTRL_MASK);
        chk("fwd", 16'(c[5:4]), 16'({userFwdActive, csFwdActive}));
        base = wordCount;
        offer(cs, 1'h1);
        if (ue) begin
            @(negedge sys_clk) rxUnitEnd = 1;
            @(negedge sys_clk) rxUnitEnd = 0;
        end
        tick(16);
        chk("words", 16'(base + add), 16'(wordCount));
        if (add != 0) chk("last", 16'(last), 16'(lastWord));
    endtask : fwd
    ////////////////////////////////////////
    initial begin
        tick(16);
        rst_n = 1;
        tick(2);
        rd(OFS_GAP_HIGH, 8'h00);
        rd(OFS_GAP_LOW, 8'h09);
        chk("gap", 16'h0009, messageGap);
        wr(OFS_GAP_HIGH, 8'hA5);
        wr(OFS_GAP_LOW, 8'h3C);
        rd(OFS_GAP_HIGH, 8'hA5);
        rd(OFS_GAP_LOW, 8'h3C);
        chk("gap", 16'hA53C, messageGap);
        // One idle edge first, so the read valid pulse has ended before the enable freezes it.
        tick(1);
        ce = 0;
        wr(OFS_GAP_HIGH, 8'h00);
        ce = 1;
        rd(OFS_GAP_HIGH, 8'hA5);
        wr(7'h20, 8'hFF);
        rd(7'h20, 8'h00);
        wr(OFS_RATIO_HIGH, 8'hFF);
        wr(OFS_PD_LOW, 8'hFF);
        rd(OFS_RATIO_HIGH, 8'h5A);
        rd(OFS_RATIO_LOW, 8'h3C);
        rd(OFS_PD_LOW, 8'h00);
        rateRatioIn = 15'h7F81;
        rd(OFS_RATIO_HIGH, 8'h7F);
        rd(OFS_RATIO_LOW, 8'h81);
        burst(1'h0, 1'h1, 32'h12345678);
        wr(OFS_PC_HIGH, 8'h00);
        rd(OFS_PC_HIGH, 8'h12);
        burst(1'h1, 1'h1, 32'h12349ABC);
        burst(1'h0, 1'h0, 32'h00000000);
        fwd(8'h20, 1'h0, 1'h0, 8'h01, 2'h1);
        fwd(8'h10, 1'h1, 1'h0, 8'h01, 2'h3);
        fwd(8'h00, 1'h0, 1'h0, 8'h00, 2'h0);
        fwd(8'h00, 1'h1, 1'h0, 8'h00, 2'h0);
        fwd(8'hE3, 1'h0, 1'h1, 8'h04, 2'h0);
        fwd(8'h23, 1'h0, 1'h1, 8'h01, 2'h1);
        fwd(8'h68, 1'h0, 1'h1, 8'h09, 2'h0);
        fwd(8'h6F, 1'h0, 1'h1, 8'h09, 2'h0);
        fwd(8'h60, 1'h0, 1'h1, 8'h01, 2'h1);
        stall = 1;
        base = wordCount;
        repeat (24) offer(1'h0, 1'h0);
        chk("full", 16'h0, 16'(rxReady));
        stall = 0;
        tick(48);
        chk("drain", 16'h1, 16'(rxReady));
        // The output register keeps one word on top of a full FIFO.
        chk("drained", 16'(FIFO_DEPTH + 1), 16'(wordCount - base));
        chk("idle", 16'h0, 16'(txValid));
        test_done;
    end
endmodule : spdif_autobuffer_status_regs_tb
